// ### hw/dsbmp_master.sv
// data cache unit end of the data-side bus master port
`timescale 1ns/1ns
`include "dsbmp_cfg.svh"
module dsbmp_master
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         proc_reset,
   input  wire logic         acc_valid,
   output logic              acc_ready,
   input  wire logic         acc_cache_hit,
   input  wire logic         acc_read,
   input  wire logic         acc_line,
   input  wire logic [31:0]  acc_addr,
   input  wire logic [2:0]   acc_nbytes,
   input  wire logic         acc_cacheable,
   input  wire logic         acc_write_through,
   input  wire logic         acc_guarded,
   input  wire logic         acc_user_attr,
   input  wire logic [1:0]   acc_priority,
   input  wire logic [255:0] acc_wr_line,
   output logic              rd_beat_valid,
   output logic [63:0]       rd_beat_data,
   output logic [2:0]        rd_beat_widx,
   output logic              rd_beat_wide,
   output logic              rd_done,
   output logic              wr_done,
   dsbmp_if.dev              bus
);
   dsbmp_pkg::dsbmp_astate_t state_ff;
   logic          read_ff;
   logic          line_ff;
   logic [31:0]   addr_ff;
   logic [7:0]    lanes_ff;
   logic [3:0]    attr_ff;
   logic [1:0]    prio_ff;
   logic [1:0]    rdq_line_ff;
   logic [1:0]    rdq_wide_ff;
   logic          rdq_wp_ff;
   logic          rdq_rp_ff;
   logic [1:0]    rd_cnt_ff;
   logic [3:0]    rd_beat_ff;
   logic          wr_busy_ff;
   logic          wr_wide_ff;
   logic [3:0]    wr_left_ff;
   logic [2:0]    wr_word_ff;
   logic [255:0]  wbuf_ff;
   logic [63:0]   wdata_ff;
   logic          rvalid_ff;
   logic [63:0]   rdata_ff;
   logic [2:0]    ridx_ff;
   logic          rwide_ff;
   logic          rdone_ff;
   logic          wdone_ff;
   logic          wanted;
   logic          room;
   logic          open;
   logic          load;
   logic          accept;
   logic          rbeat;
   logic          rlast;
   logic [3:0]    head_total;
   logic          wbeat;
   logic          wlast;
   logic [3:0]    wtotal;
   logic [2:0]    nxt_word;

   function automatic logic [7:0] word_lanes(input logic [2:0] a, input logic [2:0] n);
      logic [3:0] m;
      logic [7:0] s;
      case (n)
         3'h1:    m = 4'h1;
         3'h2:    m = 4'h3;
         3'h3:    m = 4'h7;
         default: m = 4'hf;
      endcase
      // bytes running past the word end are dropped, never spilled
      s = {4'h0, m} << a[1:0];
      return a[2] ? {s[3:0], 4'h0} : {4'h0, s[3:0]};
   endfunction

   // ************************************************************
   // request side
   // ************************************************************
   assign wanted    = acc_valid & (~acc_cache_hit | ~acc_cacheable);
   assign room      = acc_read ? (rd_cnt_ff != `DSBMP_MAX_RD) : ~wr_busy_ff;
   assign open      = (state_ff != dsbmp_pkg::as_req) & ~proc_reset;
   assign acc_ready = open & (~wanted | room);
   assign load      = open & wanted & room;
   assign accept    = (state_ff == dsbmp_pkg::as_req) & bus.data_addr_accept & ~proc_reset;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state_ff <= dsbmp_pkg::as_idle;
      else if (proc_reset)
         state_ff <= dsbmp_pkg::as_idle;
      else
         case (state_ff)
            dsbmp_pkg::as_idle,
            dsbmp_pkg::as_gap:
               state_ff <= load ? dsbmp_pkg::as_req : dsbmp_pkg::as_idle;
            dsbmp_pkg::as_req:
               if (accept)
                  state_ff <= dsbmp_pkg::as_gap;
            default:
               state_ff <= dsbmp_pkg::as_idle;
         endcase
   end

   // qualifiers are captured once and hold until the next load
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         read_ff  <= 1'b0;
         line_ff  <= 1'b0;
         addr_ff  <= `DSBMP_ADDR_RST;
         lanes_ff <= 8'h00;
         attr_ff  <= 4'h0;
         prio_ff  <= `DSBMP_PRIO_RST;
      end
      else if (load)
      begin
         read_ff  <= acc_read;
         line_ff  <= acc_line;
         addr_ff  <= acc_addr;
         lanes_ff <= acc_line ? 8'h00 : word_lanes(acc_addr[2:0], acc_nbytes);
         attr_ff  <= {acc_cacheable, acc_write_through, acc_guarded, acc_user_attr};
         prio_ff  <= acc_priority;
      end
   end

   assign bus.data_req_out        = (state_ff == dsbmp_pkg::as_req);
   assign bus.data_req_abort      = (state_ff == dsbmp_pkg::as_req) & proc_reset;
   assign bus.data_read_not_write = read_ff;
   assign bus.data_req_addr       = addr_ff;
   assign bus.data_line_size_sel  = line_ff;
   assign bus.data_byte_lanes     = lanes_ff;
   assign bus.attr_cacheable      = attr_ff[3];
   assign bus.attr_write_through  = attr_ff[2];
   assign bus.attr_guarded        = attr_ff[1];
   assign bus.attr_user_defined   = attr_ff[0];
   assign bus.data_req_priority   = prio_ff;
   assign bus.write_data_out      = wdata_ff;

   // ************************************************************
   // read return, two deep
   // ************************************************************
   assign head_total = !rdq_line_ff[rdq_rp_ff] ? `DSBMP_BEATS_WORD :
                       rdq_wide_ff[rdq_rp_ff] ? `DSBMP_BEATS_WIDE : `DSBMP_BEATS_NARROW;
   assign rbeat      = bus.read_beat_valid & (rd_cnt_ff != 2'h0) & ~proc_reset;
   assign rlast      = rbeat & (rd_beat_ff == head_total - 4'h1);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdq_line_ff <= 2'h0;
         rdq_wide_ff <= 2'h0;
         rdq_wp_ff   <= 1'b0;
         rdq_rp_ff   <= 1'b0;
         rd_cnt_ff   <= 2'h0;
         rd_beat_ff  <= 4'h0;
      end
      else if (proc_reset)
      begin
         rdq_wp_ff  <= 1'b0;
         rdq_rp_ff  <= 1'b0;
         rd_cnt_ff  <= 2'h0;
         rd_beat_ff <= 4'h0;
      end
      else
      begin
         if (accept && read_ff)
         begin
            rdq_line_ff[rdq_wp_ff] <= line_ff;
            rdq_wide_ff[rdq_wp_ff] <= bus.slave_width_ind;
            rdq_wp_ff              <= ~rdq_wp_ff;
         end
         if (rlast)
            rdq_rp_ff <= ~rdq_rp_ff;
         rd_cnt_ff  <= rd_cnt_ff + {1'b0, accept & read_ff} - {1'b0, rlast};
         rd_beat_ff <= rlast ? 4'h0 : rd_beat_ff + {3'h0, rbeat};
      end
   end

   // beats go to the fill side with their word index, in any order
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= `DSBMP_DATA_RST;
         ridx_ff   <= 3'h0;
         rwide_ff  <= 1'b0;
         rdone_ff  <= 1'b0;
      end
      else
      begin
         rvalid_ff <= rbeat;
         rdone_ff  <= rlast;
         if (rbeat)
         begin
            rdata_ff <= bus.read_data_in;
            ridx_ff  <= bus.read_beat_word_index;
            rwide_ff <= rdq_wide_ff[rdq_rp_ff];
         end
      end
   end

   assign rd_beat_valid = rvalid_ff;
   assign rd_beat_data  = rdata_ff;
   assign rd_beat_widx  = ridx_ff;
   assign rd_beat_wide  = rwide_ff;
   assign rd_done       = rdone_ff;

   // ************************************************************
   // write data, one write at a time
   // ************************************************************
   assign wtotal   = !line_ff ? `DSBMP_BEATS_WORD :
                     bus.slave_width_ind ? `DSBMP_BEATS_WIDE : `DSBMP_BEATS_NARROW;
   assign wbeat    = bus.write_beat_accept & (wr_busy_ff | (accept & ~read_ff)) & ~proc_reset;
   assign wlast    = wbeat & (wr_busy_ff ? (wr_left_ff == 4'h1) : (wtotal == 4'h1));
   // a narrow slave takes each word from its own lane of the doubleword
   assign nxt_word = wr_word_ff + (((accept ? bus.slave_width_ind : wr_wide_ff)) ? 3'h2 : 3'h1);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_busy_ff <= 1'b0;
         wr_wide_ff <= 1'b0;
         wr_left_ff <= 4'h0;
         wr_word_ff <= 3'h0;
         wbuf_ff    <= '0;
         wdata_ff   <= `DSBMP_DATA_RST;
         wdone_ff   <= 1'b0;
      end
      else if (proc_reset)
      begin
         wr_busy_ff <= 1'b0;
         wr_left_ff <= 4'h0;
         wdone_ff   <= 1'b0;
      end
      else
      begin
         wdone_ff <= wlast;
         if (load && !acc_read)
         begin
            wbuf_ff    <= acc_wr_line;
            wr_word_ff <= acc_line ? 3'h0 : acc_addr[4:2];
            wdata_ff   <= acc_wr_line[64*(acc_line ? 2'h0 : acc_addr[4:3]) +: 64];
         end
         if (accept && !read_ff)
         begin
            wr_wide_ff <= bus.slave_width_ind;
            wr_left_ff <= wtotal - {3'h0, wbeat};
            wr_busy_ff <= ~wlast;
         end
         else if (wbeat)
         begin
            wr_left_ff <= wr_left_ff - 4'h1;
            wr_busy_ff <= ~wlast;
         end
         if (wbeat)
         begin
            wr_word_ff <= nxt_word;
            wdata_ff   <= wbuf_ff[64*nxt_word[2:1] +: 64];
         end
      end
   end

   assign wr_done = wdone_ff;
endmodule

// ### hw/dsbmp_cfg.svh
// constants of the data-side bus master port
`ifndef DSBMP_CFG_SVH
`define DSBMP_CFG_SVH

// beats per transfer
`define DSBMP_BEATS_WORD   4'h1
`define DSBMP_BEATS_WIDE   4'h4
`define DSBMP_BEATS_NARROW 4'h8

// transfer-size code, bit 1 only is driven by the master
`define DSBMP_SIZE_WORD    4'h0
`define DSBMP_SIZE_LINE    4'h2

// outstanding requests
`define DSBMP_MAX_RD       2'h2

// reset values
`define DSBMP_ADDR_RST     32'h0000_0000
`define DSBMP_DATA_RST     64'h0000_0000_0000_0000
`define DSBMP_PRIO_RST     2'h0

`endif

// ### hw/dsbmp_pkg.sv
// types of the data-side bus master port
package dsbmp_pkg;

   typedef enum logic [1:0]
   {
      as_idle = 2'b00,
      as_req  = 2'b01,
      as_gap  = 2'b10
   } dsbmp_astate_t;

   typedef enum logic [1:0]
   {
      ss_idle  = 2'b00,
      ss_read  = 2'b01,
      ss_write = 2'b10
   } dsbmp_sstate_t;

endpackage

// ### hw/dsbmp_if.sv
// link between the data cache unit port and the bus slave
`timescale 1ns/1ns
interface dsbmp_if;
   logic        data_req_out;
   logic        data_read_not_write;
   logic [31:0] data_req_addr;
   logic        data_line_size_sel;
   logic [7:0]  data_byte_lanes;
   logic        attr_cacheable;
   logic        attr_write_through;
   logic        attr_guarded;
   logic        attr_user_defined;
   logic [1:0]  data_req_priority;
   logic        data_req_abort;
   logic [63:0] write_data_out;
   logic        data_addr_accept;
   logic        read_beat_valid;
   logic        write_beat_accept;
   logic        slave_width_ind;
   logic [63:0] read_data_in;
   logic [2:0]  read_beat_word_index;

   modport dev
   (
      output data_req_out,
      output data_read_not_write,
      output data_req_addr,
      output data_line_size_sel,
      output data_byte_lanes,
      output attr_cacheable,
      output attr_write_through,
      output attr_guarded,
      output attr_user_defined,
      output data_req_priority,
      output data_req_abort,
      output write_data_out,
      input  data_addr_accept,
      input  read_beat_valid,
      input  write_beat_accept,
      input  slave_width_ind,
      input  read_data_in,
      input  read_beat_word_index
   );

   modport slv
   (
      input  data_req_out,
      input  data_read_not_write,
      input  data_req_addr,
      input  data_line_size_sel,
      input  data_byte_lanes,
      input  attr_cacheable,
      input  attr_write_through,
      input  attr_guarded,
      input  attr_user_defined,
      input  data_req_priority,
      input  data_req_abort,
      input  write_data_out,
      output data_addr_accept,
      output read_beat_valid,
      output write_beat_accept,
      output slave_width_ind,
      output read_data_in,
      output read_beat_word_index
   );
endinterface

// ### hw/dsbmp_slave.sv
// bus slave end: one-master transfer sequencer plus a small flip-flop memory
`timescale 1ns/1ns
`include "dsbmp_cfg.svh"
module dsbmp_slave
#(
   parameter bit WIDE   = 1'b1,
   parameter int MEM_AW = 6
)
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [MEM_AW-1:0] peek_idx,
   output logic      [31:0]       peek_data,
   output logic      [1:0]        prio_seen,
   dsbmp_if.slv                   bus
);
   localparam int NW = 1 << MEM_AW;

   dsbmp_pkg::dsbmp_sstate_t state_ff;
   logic [31:0]        mem_ff [NW];
   logic [MEM_AW-4:0]  base_ff;
   logic [2:0]         cur_ff;
   logic [3:0]         left_ff;
   logic [7:0]         lanes_ff;
   logic               line_ff;
   logic               grd_ff;
   logic               rvalid_ff;
   logic [63:0]        rdata_ff;
   logic [2:0]         ridx_ff;
   logic [31:0]        peek_ff;
   logic [1:0]         prio_ff;
   logic               accept;
   logic               req_line;
   logic [3:0]         size_code;
   logic [2:0]         step;
   logic [2:0]         ev;
   logic [63:0]        dw;
   logic [63:0]        mask;

   // the other size bits are held at zero here
   assign size_code = {2'b00, bus.data_line_size_sel, 1'b0};
   assign req_line  = (size_code == `DSBMP_SIZE_LINE);
   assign accept    = (state_ff == dsbmp_pkg::ss_idle) & bus.data_req_out & ~bus.data_req_abort;
   assign step      = WIDE ? 3'h2 : 3'h1;
   assign ev        = {cur_ff[2:1], 1'b0};
   assign dw        = {mem_ff[{base_ff, ev | 3'h1}], mem_ff[{base_ff, ev}]};

   // line transfers move every byte whatever the lanes say
   always_comb
   begin
      mask = '1;
      for (int b = 0; b < 8; b++)
         if (!line_ff && !lanes_ff[b])
            mask[8*b +: 8] = 8'h00;
   end

   assign bus.data_addr_accept     = accept;
   assign bus.slave_width_ind      = WIDE;
   assign bus.write_beat_accept    = (state_ff == dsbmp_pkg::ss_write);
   assign bus.read_beat_valid      = rvalid_ff;
   assign bus.read_data_in         = rdata_ff;
   assign bus.read_beat_word_index = ridx_ff;
   assign peek_data                = peek_ff;
   assign prio_seen                = prio_ff;

   // ************************************************************
   // transfer sequencing
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= dsbmp_pkg::ss_idle;
         base_ff  <= '0;
         cur_ff   <= 3'h0;
         left_ff  <= 4'h0;
         lanes_ff <= 8'h00;
         line_ff  <= 1'b0;
         grd_ff   <= 1'b0;
         prio_ff  <= `DSBMP_PRIO_RST;
      end
      else if (accept)
      begin
         state_ff <= bus.data_read_not_write ? dsbmp_pkg::ss_read : dsbmp_pkg::ss_write;
         base_ff  <= bus.data_req_addr[MEM_AW+1:5];
         lanes_ff <= bus.data_byte_lanes;
         line_ff  <= req_line;
         grd_ff   <= bus.attr_guarded;
         prio_ff  <= bus.data_req_priority;
         // reads start at the target word, or its even word when wide; writes of a line at word zero
         if (req_line && !bus.data_read_not_write)
            cur_ff <= 3'h0;
         else if (WIDE)
            cur_ff <= {bus.data_req_addr[4:3], 1'b0};
         else
            cur_ff <= bus.data_req_addr[4:2];
         if (!req_line)
            left_ff <= `DSBMP_BEATS_WORD;
         else
            left_ff <= WIDE ? `DSBMP_BEATS_WIDE : `DSBMP_BEATS_NARROW;
      end
      else if (state_ff != dsbmp_pkg::ss_idle)
      begin
         cur_ff  <= cur_ff + step;
         left_ff <= left_ff - 4'h1;
         if (left_ff == 4'h1)
            state_ff <= dsbmp_pkg::ss_idle;
      end
   end

   // only this master is served, so the shared read path never collides
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= `DSBMP_DATA_RST;
         ridx_ff   <= 3'h0;
      end
      else
      begin
         rvalid_ff <= (state_ff == dsbmp_pkg::ss_read);
         ridx_ff   <= cur_ff;
         // guarded word reads return only the requested bytes
         if (!WIDE)
            rdata_ff <= (cur_ff[0] ? {mem_ff[{base_ff, cur_ff}], 32'h0000_0000}
                                   : {32'h0000_0000, mem_ff[{base_ff, cur_ff}]})
                        & (grd_ff ? mask : '1);
         else
            rdata_ff <= dw & (grd_ff ? mask : '1);
      end
   end

   // ************************************************************
   // storage
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (state_ff == dsbmp_pkg::ss_write)
         for (int b = 0; b < 8; b++)
            if (mask[8*b] && (WIDE || cur_ff[0] == b[2]))
               mem_ff[{base_ff, ev | {2'b00, b[2]}}][8*b[1:0] +: 8] <=
                  bus.write_data_out[8*b +: 8];
      peek_ff <= mem_ff[peek_idx];
   end
endmodule

// ### sim/dsbmp_monitor.sv
// concurrent checks on the data-side bus master link
`timescale 1ns/1ns
module dsbmp_monitor
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        data_req_out,
   input wire logic        data_read_not_write,
   input wire logic [31:0] data_req_addr,
   input wire logic        data_line_size_sel,
   input wire logic [7:0]  data_byte_lanes,
   input wire logic [1:0]  data_req_priority,
   input wire logic        data_req_abort,
   input wire logic        data_addr_accept,
   input wire logic        read_beat_valid,
   input wire logic        write_beat_accept,
   input wire logic        slave_width_ind,
   input wire logic [2:0]  read_beat_word_index
);
   // ****************************************
   // link properties
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [3:0] nib;
   logic       acc_rd;
   logic       acc_wr;
   assign nib    = data_byte_lanes[7:4] | data_byte_lanes[3:0];
   assign acc_rd = data_addr_accept & data_read_not_write;
   assign acc_wr = data_addr_accept & ~data_read_not_write;
   property p_lanes_word;
      data_req_out && !data_line_size_sel |-> (nib inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3,
         4'h6, 4'hc, 4'h7, 4'he, 4'hf}) && (data_byte_lanes[7:4] == 4'h0 || data_byte_lanes[3:0] == 4'h0);
   endproperty
   a_lanes_word: assert property (p_lanes_word) else $error("lanes not contiguous");
   property p_req_hold;
      data_req_out && !data_addr_accept && !data_req_abort |=> data_req_out
         && $stable(data_req_addr) && $stable(data_read_not_write) && $stable(data_line_size_sel)
         && $stable(data_byte_lanes) && $stable(data_req_priority);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request moved before accept");
   property p_req_gap;
      data_addr_accept |=> !data_req_out;
   endproperty
   a_req_gap: assert property (p_req_gap) else $error("request too soon after accept");
   property p_abort_drop;
      data_req_abort |-> data_req_out && !data_addr_accept ##1 !data_req_out;
   endproperty
   a_abort_drop: assert property (p_abort_drop) else $error("abort misbehaved");
   property p_line_rd;
      acc_rd && data_line_size_sel && slave_width_ind |-> ##1 !read_beat_valid ##1
         read_beat_valid [*4] ##1 !read_beat_valid;
   endproperty
   a_line_rd: assert property (p_line_rd) else $error("line read beat count");
   property p_word_rd;
      acc_rd && !data_line_size_sel |-> ##1 !read_beat_valid ##1 read_beat_valid
         ##1 !read_beat_valid;
   endproperty
   a_word_rd: assert property (p_word_rd) else $error("word read not one beat");
   property p_line_wr;
      acc_wr && data_line_size_sel && slave_width_ind |=> write_beat_accept [*4]
         ##1 !write_beat_accept;
   endproperty
   a_line_wr: assert property (p_line_wr) else $error("line write beat count");
   property p_word_wr;
      acc_wr && !data_line_size_sel |=> write_beat_accept ##1 !write_beat_accept;
   endproperty
   a_word_wr: assert property (p_word_wr) else $error("word write not one beat");
   property p_idx_wrap;
      read_beat_valid && $past(read_beat_valid) && slave_width_ind
         |-> read_beat_word_index == $past(read_beat_word_index) + 3'h2;
   endproperty
   a_idx_wrap: assert property (p_idx_wrap) else $error("read beat order");
   c_abort: cover property (data_req_abort);
   c_line_rd: cover property (acc_rd && data_line_size_sel);
   c_line_wr: cover property (acc_wr && data_line_size_sel);
endmodule

// ### sim/tb.sv
// self-checking bench of the data-side bus master port
`timescale 1ns/1ns
`define CHK(what, exp, seen) \
   begin \
      checks_done++; \
      if ((seen) !== (exp)) \
      begin \
         error_cnt++; \
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen); \
      end \
   end
module tb;
   // ****************************************
   // stimulus, capture and sequence
   // ****************************************
   logic         clk = 1'b0, rst_n = 1'b0, proc_reset = 1'b0, acc_valid = 1'b0;
   logic         acc_cache_hit = 1'b0, acc_read = 1'b0, acc_line = 1'b0, acc_cacheable = 1'b0;
   logic         acc_write_through = 1'b0, acc_guarded = 1'b0, acc_user_attr = 1'b0;
   logic [31:0]  acc_addr = 32'h0000_0000;
   logic [2:0]   acc_nbytes = 3'h4;
   logic [1:0]   acc_priority = 2'h0;
   logic [255:0] acc_wr_line = '0, wl;
   logic [5:0]   peek_idx = 6'h00;
   logic         acc_ready, rd_beat_valid, rd_beat_wide, rd_done, wr_done;
   logic [63:0]  rd_beat_data;
   logic [2:0]   rd_beat_widx;
   logic [31:0]  peek_data, ex;
   logic [1:0]   prio_seen;
   logic [31:0]  got [8];
   logic [2:0]   idxq [$];
   logic [7:0]   cap_lanes, lanes;
   logic [4:0]   cap_sa;
   logic [3:0]   at;
   int           error_cnt = 0, checks_done = 0, rd_dn = 0, wr_dn = 0, req_cnt = 0;
   int           abort_cnt = 0, k, m;
   dsbmp_if bus_if();
   dsbmp_master i_dsbmp_master (.clk, .rst_n, .proc_reset, .acc_valid, .acc_ready, .acc_cache_hit,
      .acc_read, .acc_line, .acc_addr, .acc_nbytes, .acc_cacheable, .acc_write_through,
      .acc_guarded, .acc_user_attr, .acc_priority, .acc_wr_line, .rd_beat_valid, .rd_beat_data,
      .rd_beat_widx, .rd_beat_wide, .rd_done, .wr_done, .bus(bus_if));
   dsbmp_slave #(.WIDE(1'b1), .MEM_AW(6)) i_dsbmp_slave (.clk, .rst_n, .peek_idx, .peek_data,
      .prio_seen, .bus(bus_if));
   dsbmp_monitor i_dsbmp_monitor (.clk, .rst_n, .data_req_out(bus_if.data_req_out),
      .data_read_not_write(bus_if.data_read_not_write), .data_req_addr(bus_if.data_req_addr),
      .data_line_size_sel(bus_if.data_line_size_sel), .data_byte_lanes(bus_if.data_byte_lanes),
      .data_req_priority(bus_if.data_req_priority), .data_req_abort(bus_if.data_req_abort),
      .data_addr_accept(bus_if.data_addr_accept), .read_beat_valid(bus_if.read_beat_valid),
      .write_beat_accept(bus_if.write_beat_accept), .slave_width_ind(bus_if.slave_width_ind),
      .read_beat_word_index(bus_if.read_beat_word_index));
   always #5 clk = ~clk;
   // user-side beats and accepted link requests are recorded at every rising edge
   always @(posedge clk)
   begin
      if (rd_beat_valid === 1'b1)
      begin
         got[rd_beat_widx] <= rd_beat_data[32*rd_beat_widx[0] +: 32];
         if (rd_beat_wide === 1'b1)
            got[rd_beat_widx | 3'h1] <= rd_beat_data[63:32];
         idxq.push_back(rd_beat_widx);
      end
      if (rd_done === 1'b1)
         rd_dn++;
      if (wr_done === 1'b1)
         wr_dn++;
      if (bus_if.data_req_abort === 1'b1)
         abort_cnt++;
      if (bus_if.data_req_out === 1'b1 && bus_if.data_addr_accept === 1'b1)
      begin
         req_cnt++;
         cap_lanes = bus_if.data_byte_lanes;
         cap_sa = {bus_if.data_line_size_sel, bus_if.attr_cacheable, bus_if.attr_write_through,
                   bus_if.attr_guarded, bus_if.attr_user_defined};
      end
   end
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic hang();
      error_cnt++;
      conclude();
   endtask
   // rlh = read, line, cache hit; ready is looked at mid-cycle to avoid an edge race
   task automatic issue(input logic [2:0] rlh, input logic [31:0] a, input logic [2:0] n,
                        input logic [3:0] attr, input logic [1:0] pr);
      logic tk = 1'b0;
      acc_valid <= 1'b1;
      {acc_read, acc_line, acc_cache_hit, acc_addr, acc_nbytes, acc_priority} <= {rlh, a, n, pr};
      {acc_cacheable, acc_write_through, acc_guarded, acc_user_attr} <= attr;
      for (int i = 0; i < 100 && !tk; i++)
      begin
         @(negedge clk);
         tk = (acc_ready === 1'b1);
         @(posedge clk);
      end
      acc_valid <= 1'b0;
      if (!tk)
         hang();
      else
         @(posedge clk);
   endtask
   task automatic wait_cnt(ref int c, input int n);
      for (int i = 0; i < 300 && c < n; i++)
         @(posedge clk);
      if (c < n)
         hang();
      else
         @(posedge clk);
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (k = 0; k < 8; k++)
         wl[32*k +: 32] = 32'h5a00_0000 + 32'h0001_0101 * k;
      acc_wr_line <= wl;
      issue(3'b010, 32'h0000_0040, 3'h4, 4'b1101, 2'h3);
      wait_cnt(wr_dn, 1);
      `CHK("write size and attrs", 5'b11101, cap_sa)
      `CHK("line lanes", 8'h00, cap_lanes)
      `CHK("write priority", 2'h3, prio_seen)
      for (k = 0; k < 8; k++)
      begin
         peek_idx <= 6'(16 + k);
         @(posedge clk);
         @(negedge clk);
         `CHK("stored word", wl[32*k +: 32], peek_data)
      end
      @(posedge clk);
      idxq.delete();
      issue(3'b110, 32'h0000_0054, 3'h4, 4'h0, 2'h1);
      wait_cnt(rd_dn, 1);
      `CHK("line beats", 4, idxq.size())
      `CHK("first index", 3'h4, idxq[0])
      for (k = 0; k < 8; k++)
         `CHK("line word", wl[32*k +: 32], got[k])
      // every offset and length; offset 5 is guarded, so unasked bytes read as zero
      for (k = 0; k < 8; k++)
      begin
         m = k % 4 + 1;
         at = (k == 5) ? 4'h2 : 4'h0;
         lanes = (8'((1 << m) - 1) << k) & ((k < 4) ? 8'h0f : 8'hf0);
         ex = wl[32*(k/4) +: 32];
         if (k == 5)
            ex = ex & 32'h00ff_ff00;
         got[k/4] = 32'h0000_0000;
         issue(3'b100, 32'h0000_0040 + k, 3'(m), at, 2'(k));
         wait_cnt(rd_dn, k + 2);
         `CHK("word lanes", lanes, cap_lanes)
         `CHK("word attrs", {1'b0, at}, cap_sa)
         `CHK("word priority", 2'(k), prio_seen)
         `CHK("word data", ex, got[k/4])
      end
      m = req_cnt;
      issue(3'b101, 32'h0000_0040, 3'h4, 4'h8, 2'h0);
      repeat (6) @(posedge clk);
      `CHK("cached hit", m, req_cnt)
      issue(3'b101, 32'h0000_0044, 3'h4, 4'h0, 2'h0);
      wait_cnt(rd_dn, 10);
      `CHK("uncached hit", m + 1, req_cnt)
      idxq.delete();
      issue(3'b110, 32'h0000_0040, 3'h4, 4'h0, 2'h2);
      issue(3'b110, 32'h0000_004c, 3'h4, 4'h0, 2'h2);
      wait_cnt(rd_dn, 12);
      `CHK("pipelined beats", 8, idxq.size())
      `CHK("second first index", 3'h2, idxq[4])
      `CHK("no abort so far", 0, abort_cnt)
      issue(3'b110, 32'h0000_0040, 3'h4, 4'h0, 2'h0);
      issue(3'b100, 32'h0000_0044, 3'h4, 4'h0, 2'h0);
      proc_reset <= 1'b1;
      repeat (2) @(posedge clk);
      proc_reset <= 1'b0;
      `CHK("abort on reset", 1'b1, abort_cnt > 0)
      repeat (12) @(posedge clk);
      m = rd_dn;
      got[2] = 32'h0000_0000;
      issue(3'b100, 32'h0000_0048, 3'h4, 4'h0, 2'h0);
      wait_cnt(rd_dn, m + 1);
      `CHK("read after abort", wl[95:64], got[2])
      // bytes two and three of word one only; the rest of the word must survive
      acc_wr_line <= ~wl;
      issue(3'b000, 32'h0000_0046, 3'h2, 4'h0, 2'h0);
      wait_cnt(wr_dn, 2);
      `CHK("word write lanes", 8'hc0, cap_lanes)
      peek_idx <= 6'h11;
      @(posedge clk);
      @(negedge clk);
      `CHK("word written", {~wl[63:48], wl[47:32]}, peek_data)
      conclude();
   end
endmodule
